// *** design/cc_ctrl.sv ***
/*
 * Four-way set-associative cache controller: tag store, lookup, fill,
 * write-through, snoop invalidation and the cache RAM strobes.
 * Assumes processor signals are synchronous to ref_clk and that the
 * system end completes every cycle it is asked to run.
 */
module cc_ctrl (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Processor and system link
    cc_bus_if.dev            bus,
    // Board strap for the programming port
    input  wire logic [3:0]  io_base,
    // Noncached region
    input  wire logic        nc_enable,
    input  wire logic [31:2] nc_base,
    input  wire logic [31:2] nc_mask,
    // Status
    output logic             io_port_hit
);

    typedef struct packed {
        cc_pkg::cc_state_t              state;
        logic [cc_pkg::IDX_W-1:0]       flush_idx;
        logic [31:2]                    addr;
        logic [3:0]                     lanes_n;
        logic                           hit;
        logic [cc_pkg::WAY_W-1:0]       way;
        logic [cc_pkg::WAY_W-1:0]       rr;
        logic                           ready_drv;
        logic                           early_n;
        logic                           rd_req_n;
        logic                           wr_req_n;
        logic                           unc_n;
        logic                           oe_n;
        logic                           fault;
        logic [cc_pkg::CADDR_W-1:0]     caddr;
        logic [3*cc_pkg::IO_SEL_W-1:0]  io_sync;
        logic [cc_pkg::IO_SEL_W-1:0]    io_sel;
    } cc_ctrl_state_t;

    cc_ctrl_state_t r_reg;
    cc_ctrl_state_t r_next;

    // ************************************************************
    // Tag store
    // ************************************************************
    logic [cc_pkg::TAG_W-1:0] tag_mem   [cc_pkg::WAYS][cc_pkg::SETS];
    logic                     valid_mem [cc_pkg::WAYS][cc_pkg::SETS];

    logic [cc_pkg::IDX_W-1:0] idx;
    logic [cc_pkg::TAG_W-1:0] tag;
    logic [cc_pkg::WAYS-1:0]  way_hit;
    logic [cc_pkg::WAYS-1:0]  way_valid;
    logic [cc_pkg::WAYS-1:0]  vw;
    logic [cc_pkg::WAYS-1:0]  tw;
    logic                     vval;
    logic [cc_pkg::IDX_W-1:0] widx;

    assign idx = bus.addr[cc_pkg::TAG_LSB-1:cc_pkg::IDX_LSB];
    assign tag = bus.addr[31:cc_pkg::TAG_LSB];

    for (genvar w = 0; w < cc_pkg::WAYS; w++) begin : g_way
        assign way_valid[w] = valid_mem[w][idx];
        assign way_hit[w]   = valid_mem[w][idx] && (tag_mem[w][idx] == tag);

        // The tag store has no reset; the flush sweep clears its valid bits instead.
        always_ff @(posedge ref_clk) begin
            if (vw[w]) begin
                valid_mem[w][widx] <= vval;
            end
            if (tw[w]) begin
                tag_mem[w][widx] <= r_reg.addr[31:cc_pkg::TAG_LSB];
            end
        end
    end

    // ************************************************************
    // Lookup helpers
    // ************************************************************
    logic [cc_pkg::WAY_W-1:0] hit_way;
    logic [cc_pkg::WAY_W-1:0] victim;
    logic                     any_hit;
    logic                     multi_hit;
    logic                     take;
    logic                     done;
    logic                     unc_hit;

    always_comb begin
        hit_way = r_reg.rr;
        victim  = r_reg.rr;
        for (int w = cc_pkg::WAYS - 1; w >= 0; w--) begin
            if (way_hit[w]) begin
                hit_way = cc_pkg::WAY_W'(w);
            end
            if (!way_valid[w]) begin
                victim = cc_pkg::WAY_W'(w);
            end
        end
    end

    assign any_hit   = |way_hit;
    assign multi_hit = (way_hit & (way_hit - 4'h1)) != 4'h0;
    assign done      = !bus.main_mem_done_n;
    assign unc_hit   = nc_enable && bus.data_not_ctrl
                       && ((bus.addr & nc_mask) == (nc_base & nc_mask));
    assign take      = (r_reg.state == cc_pkg::ST_IDLE) || r_reg.ready_drv;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        r_next           = r_reg;
        vw               = '0;
        tw               = '0;
        vval             = 1'b0;
        widx             = r_reg.addr[cc_pkg::TAG_LSB-1:cc_pkg::IDX_LSB];
        r_next.ready_drv = 1'b0;
        r_next.early_n   = 1'b1;
        r_next.oe_n      = 1'b1;
        r_next.io_sync   = {r_reg.io_sync[2*cc_pkg::IO_SEL_W-1:0], io_base};
        if (r_reg.io_sync[2*cc_pkg::IO_SEL_W-1:cc_pkg::IO_SEL_W]
            == r_reg.io_sync[3*cc_pkg::IO_SEL_W-1:2*cc_pkg::IO_SEL_W]) begin
            r_next.io_sel = r_reg.io_sync[3*cc_pkg::IO_SEL_W-1:2*cc_pkg::IO_SEL_W];
        end
        case (r_reg.state)
            cc_pkg::ST_FLUSH: begin
                vw               = '1;
                widx             = r_reg.flush_idx;
                r_next.flush_idx = r_reg.flush_idx + 11'h1;
                if (&r_reg.flush_idx) begin
                    r_next.state = cc_pkg::ST_IDLE;
                end
            end
            cc_pkg::ST_IDLE, cc_pkg::ST_HIT_RD, cc_pkg::ST_IO_ACK: begin
                r_next.state = cc_pkg::ST_IDLE;
            end
            cc_pkg::ST_FILL: begin
                if (done) begin
                    vw[r_reg.way]   = 1'b1;
                    tw[r_reg.way]   = 1'b1;
                    vval            = 1'b1;
                    r_next.rd_req_n = 1'b1;
                    r_next.rr       = r_reg.rr + 2'h1;
                    r_next.state    = cc_pkg::ST_IDLE;
                end
            end
            cc_pkg::ST_WRITE, cc_pkg::ST_BYPASS: begin
                if (done) begin
                    r_next.rd_req_n = 1'b1;
                    r_next.wr_req_n = 1'b1;
                    r_next.unc_n    = 1'b1;
                    r_next.state    = cc_pkg::ST_IDLE;
                end
            end
            default: begin
                r_next.state = cc_pkg::ST_IDLE;
            end
        endcase
        // A completion nobody asked for means the two ends disagree.
        if (done && r_reg.rd_req_n && r_reg.wr_req_n) begin
            r_next.fault = 1'b1;
        end
        if (take && !bus.cycle_begin_strobe_n) begin
            r_next.addr    = bus.addr;
            r_next.lanes_n = bus.byte_lane_en_n;
            r_next.hit     = any_hit;
            r_next.way     = hit_way;
            r_next.caddr   = {hit_way, idx};
            r_next.state   = cc_pkg::ST_IDLE;
            if (multi_hit) begin
                r_next.fault = 1'b1;
            end
            if (!bus.dma_snoop_n) begin
                vw   = way_hit;
                widx = idx;
            end else begin
                r_next.early_n = 1'b0;
                if (!bus.lock_n) begin
                    vw   = way_hit;
                    widx = idx;
                end
                if (!bus.mem_not_io
                    && bus.addr[cc_pkg::IO_SEL_LSB+:cc_pkg::IO_SEL_W] == r_reg.io_sel) begin
                    r_next.ready_drv = 1'b1;
                    r_next.state     = cc_pkg::ST_IO_ACK;
                end else if (!bus.mem_not_io || !bus.lock_n || unc_hit) begin
                    r_next.rd_req_n = bus.write_not_read;
                    r_next.wr_req_n = !bus.write_not_read;
                    r_next.unc_n    = !(unc_hit && bus.mem_not_io);
                    r_next.state    = cc_pkg::ST_BYPASS;
                end else if (bus.write_not_read) begin
                    r_next.wr_req_n = 1'b0;
                    r_next.state    = cc_pkg::ST_WRITE;
                end else if (any_hit) begin
                    r_next.ready_drv = 1'b1;
                    r_next.oe_n      = 1'b0;
                    r_next.state     = cc_pkg::ST_HIT_RD;
                end else begin
                    r_next.rd_req_n = 1'b0;
                    r_next.way      = victim;
                    r_next.caddr    = {victim, idx};
                    r_next.state    = cc_pkg::ST_FILL;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg          <= '0;
            r_reg.state    <= cc_pkg::ST_FLUSH;
            r_reg.lanes_n  <= 4'hf;
            r_reg.early_n  <= 1'b1;
            r_reg.rd_req_n <= 1'b1;
            r_reg.wr_req_n <= 1'b1;
            r_reg.unc_n    <= 1'b1;
            r_reg.oe_n     <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Write strobes follow the acknowledge in the same cycle, because the
    // fill data is only on the data bus while the system completes.
    always_comb begin
        bus.cache_we_n = 4'hf;
        if (done && r_reg.state == cc_pkg::ST_FILL) begin
            bus.cache_we_n = 4'h0;
        end else if (done && r_reg.state == cc_pkg::ST_WRITE && r_reg.hit) begin
            bus.cache_we_n = r_reg.lanes_n;
        end
    end

    assign bus.dev_ready_n_o        = 1'b0;
    assign bus.dev_ready_oe         = r_reg.ready_drv;
    assign bus.early_addr_req_n     = r_reg.early_n;
    assign bus.main_mem_read_req_n  = r_reg.rd_req_n;
    assign bus.main_mem_write_req_n = r_reg.wr_req_n;
    assign bus.sample               = take || done;
    assign bus.uncached_access_n    = r_reg.unc_n;
    assign bus.cache_fault          = r_reg.fault;
    assign bus.cache_addr           = r_reg.caddr;
    assign bus.cache_oe_n           = r_reg.oe_n;
    assign io_port_hit              = r_reg.state == cc_pkg::ST_IO_ACK;

endmodule : cc_ctrl

// *** shared/cc_pkg.sv ***
/*
 * Shared constants and state types for the cache controller and its
 * system memory end.
 * Assumes a synchronous local bus clocked by ref_clk on both ends.
 */
package cc_pkg;

    // ************************************************************
    // Cache geometry
    // ************************************************************
    localparam int WAYS     = 4;
    localparam int WAY_W    = 2;
    localparam int IDX_W    = 11;
    localparam int SETS     = 2048;
    localparam int IDX_LSB  = 2;
    localparam int TAG_LSB  = 13;
    localparam int TAG_W    = 19;
    localparam int LANES    = 4;
    localparam int CADDR_W  = 13;

    // ************************************************************
    // Programming port decode
    // ************************************************************
    localparam int IO_SEL_W   = 4;
    localparam int IO_SEL_LSB = 4;

    // ************************************************************
    // State encodings
    // ************************************************************
    typedef enum logic [2:0] {
        ST_FLUSH,
        ST_IDLE,
        ST_HIT_RD,
        ST_IO_ACK,
        ST_FILL,
        ST_WRITE,
        ST_BYPASS
    } cc_state_t;

    typedef enum logic [1:0] {
        SY_IDLE,
        SY_WAIT,
        SY_DONE
    } cc_sys_state_t;

endpackage : cc_pkg

// *** shared/cc_bus_if.sv ***
/*
 * Processor local bus, system memory handshake and cache RAM pins.
 * Assumes the processor and the cache RAMs are modelled outside; the
 * shared ready line is resolved here from the two drivers' enables.
 */
interface cc_bus_if;

    // Processor cycle
    logic [31:2] addr;
    logic [3:0]  byte_lane_en_n;
    logic        cycle_begin_strobe_n;
    logic        write_not_read;
    logic        mem_not_io;
    logic        data_not_ctrl;
    logic        lock_n;
    logic        early_addr_req_n;
    // Shared completion line
    logic        dev_ready_n_o;
    logic        dev_ready_oe;
    logic        sys_ready_n_o;
    logic        sys_ready_oe;
    logic        ready_n;
    // System memory handshake
    logic        dma_snoop_n;
    logic        main_mem_read_req_n;
    logic        main_mem_write_req_n;
    logic        main_mem_done_n;
    logic        sample;
    logic        uncached_access_n;
    logic        cache_fault;
    // Cache RAMs
    logic [12:0] cache_addr;
    logic [3:0]  cache_we_n;
    logic        cache_oe_n;

    assign ready_n = dev_ready_oe ? dev_ready_n_o : (sys_ready_oe ? sys_ready_n_o : 1'b1);

    modport dev (
        input  addr, byte_lane_en_n, cycle_begin_strobe_n, write_not_read, mem_not_io,
        input  data_not_ctrl, lock_n, dma_snoop_n, main_mem_done_n,
        output early_addr_req_n, dev_ready_n_o, dev_ready_oe, main_mem_read_req_n,
        output main_mem_write_req_n, sample, uncached_access_n, cache_fault,
        output cache_addr, cache_we_n, cache_oe_n
    );

    modport sys (
        input  addr, byte_lane_en_n, cycle_begin_strobe_n, write_not_read, lock_n,
        input  main_mem_read_req_n, main_mem_write_req_n, sample, uncached_access_n,
        output dma_snoop_n, sys_ready_n_o, sys_ready_oe, main_mem_done_n
    );

endinterface : cc_bus_if

// *** design/cc_sys_end.sv ***
/*
 * System memory end: runs the main memory transfers the controller
 * requests, completes them on the shared ready line and arbitrates
 * bus-master snoops against exclusive cycles.
 * Assumes the memory behind mem_ack is synchronous to ref_clk.
 */
module cc_sys_end (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Controller link
    cc_bus_if.sys            bus,
    // Memory side
    output logic             mem_start,
    output logic             mem_write,
    output logic [31:2]      mem_addr,
    output logic [3:0]       mem_lanes_n,
    output logic             mem_uncached,
    input  wire logic        mem_ack,
    // Other bus master
    input  wire logic        dma_req,
    output logic             excl_hold
);

    typedef struct packed {
        cc_pkg::cc_sys_state_t state;
        logic                  start;
        logic                  write;
        logic [31:2]           addr;
        logic [3:0]            lanes_n;
        logic                  unc;
        logic                  snoop_n;
        logic                  hold;
    } cc_sys_reg_t;

    cc_sys_reg_t r_reg;
    cc_sys_reg_t r_next;

    always_comb begin
        r_next         = r_reg;
        r_next.start   = 1'b0;
        r_next.hold    = !bus.lock_n;
        // Another master only gets the bus outside exclusive cycles.
        r_next.snoop_n = !(dma_req && bus.lock_n);
        if (bus.sample && !bus.cycle_begin_strobe_n) begin
            r_next.addr    = bus.addr;
            r_next.lanes_n = bus.byte_lane_en_n;
        end
        case (r_reg.state)
            cc_pkg::SY_IDLE: begin
                if (!bus.main_mem_read_req_n || !bus.main_mem_write_req_n) begin
                    r_next.start = 1'b1;
                    r_next.write = !bus.main_mem_write_req_n;
                    r_next.unc   = !bus.uncached_access_n;
                    r_next.state = cc_pkg::SY_WAIT;
                end
            end
            cc_pkg::SY_WAIT: begin
                if (mem_ack) begin
                    r_next.state = cc_pkg::SY_DONE;
                end
            end
            cc_pkg::SY_DONE: begin
                r_next.state = cc_pkg::SY_IDLE;
            end
            default: begin
                r_next.state = cc_pkg::SY_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg         <= '0;
            r_reg.state   <= cc_pkg::SY_IDLE;
            r_reg.lanes_n <= 4'hf;
            r_reg.snoop_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign bus.main_mem_done_n = !(r_reg.state == cc_pkg::SY_DONE);
    assign bus.sys_ready_n_o   = 1'b0;
    assign bus.sys_ready_oe    = r_reg.state == cc_pkg::SY_DONE;
    assign bus.dma_snoop_n     = r_reg.snoop_n;
    assign excl_hold           = r_reg.hold;
    assign mem_start           = r_reg.start;
    assign mem_write           = r_reg.write;
    assign mem_addr            = r_reg.addr;
    assign mem_lanes_n         = r_reg.lanes_n;
    assign mem_uncached        = r_reg.unc;

endmodule : cc_sys_end

// *** verif/cc_props.sv ***
/*
 * Checker for the link that joins cc_ctrl and cc_sys_end.
 * Assumes it sits beside cc_bus_if and is fed its signals by name.
 */
module cc_props (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset_n,
    // Link signals
    input wire logic       cycle_begin_strobe_n,
    input wire logic       dma_snoop_n,
    input wire logic       sample,
    input wire logic       early_addr_req_n,
    input wire logic       dev_ready_oe,
    input wire logic       sys_ready_oe,
    input wire logic       ready_n,
    input wire logic       main_mem_read_req_n,
    input wire logic       main_mem_write_req_n,
    input wire logic       main_mem_done_n,
    input wire logic [3:0] cache_we_n,
    input wire logic       cache_oe_n,
    input wire logic       cache_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Helper logic
    // ************************************************************
    logic [11:0] boot_reg;
    logic        take;

    // Counts cycles since reset so the tag sweep can be watched.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            boot_reg <= 12'h000;
        end else if (boot_reg != 12'h800) begin
            boot_reg <= boot_reg + 12'h001;
        end
    end

    assign take = !cycle_begin_strobe_n && sample && main_mem_read_req_n && main_mem_write_req_n;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_FLUSH_NO_TAKE: assert property (boot_reg < 12'h7fe |-> !sample)
        else $error("strobe accepted during tag sweep");
    AST_EARLY_ADDR: assert property (take && dma_snoop_n |=> !early_addr_req_n)
        else $error("no early address request after strobe");
    AST_SNOOP_SILENT: assert property (take && !dma_snoop_n |=>
        main_mem_read_req_n && main_mem_write_req_n && !dev_ready_oe)
        else $error("snoop cycle started a transfer");
    AST_DEV_READY_CAUSE: assert property (dev_ready_oe |-> !ready_n && $past(!cycle_begin_strobe_n))
        else $error("device ready not one cycle after strobe");
    AST_READY_OWNER: assert property (!ready_n |-> dev_ready_oe ^ sys_ready_oe)
        else $error("ready low without exactly one driver");
    AST_SYS_READY_DONE: assert property (sys_ready_oe |-> !main_mem_done_n)
        else $error("system ready without done");
    AST_DONE_RELEASE: assert property (!main_mem_done_n && cycle_begin_strobe_n |=>
        main_mem_read_req_n && main_mem_write_req_n)
        else $error("request held past done");
    AST_RD_HOLD: assert property (!main_mem_read_req_n && main_mem_done_n |=> !main_mem_read_req_n)
        else $error("read request dropped early");
    AST_WR_HOLD: assert property (!main_mem_write_req_n && main_mem_done_n |=> !main_mem_write_req_n)
        else $error("write request dropped early");
    AST_ONE_REQ: assert property (main_mem_read_req_n || main_mem_write_req_n)
        else $error("read and write requested together");
    AST_WE_AT_DONE: assert property (cache_we_n != 4'hf |-> !main_mem_done_n && cache_oe_n)
        else $error("cache write outside done cycle");
    AST_SAMPLE_DONE: assert property (!main_mem_done_n |-> sample)
        else $error("sample missing at completion");
    AST_FAULT_STICKY: assert property (cache_fault |=> cache_fault)
        else $error("fault cleared without reset");
endmodule : cc_props

// *** verif/cpu_cache_controller_tb.sv ***
/*
 * Self-checking bench: both ends joined by cc_bus_if, a reference set
 * of cached word addresses, and a memory that acks after 1 to 4 cycles.
 * Assumes the package, interface and both design modules are compiled first.
 */
module cpu_cache_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0]  IO_B   = 4'h5;
    localparam logic [18:0] NC_TAG = 19'h00009;
    logic        ref_clk, reset_n, nc_enable, mem_ack, dma_req;
    logic        io_port_hit, mem_start, mem_write, mem_uncached, excl_hold;
    logic [3:0]  io_base, mem_lanes_n;
    logic [31:2] nc_base, nc_mask, mem_addr, pa;
    int          n_errors, tests_run, ack_cnt, ack_dly, i, n;
    bit          vld [logic [31:2]];
    cc_bus_if bif ();
    cc_ctrl u_cc_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bif.dev), .io_base(io_base),
        .nc_enable(nc_enable), .nc_base(nc_base), .nc_mask(nc_mask), .io_port_hit(io_port_hit));
    cc_sys_end u_cc_sys_end (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bif.sys), .mem_start(mem_start),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_lanes_n(mem_lanes_n), .mem_uncached(mem_uncached),
        .mem_ack(mem_ack), .dma_req(dma_req), .excl_hold(excl_hold));
    cc_props u_cc_props (.ref_clk(ref_clk), .reset_n(reset_n), .cycle_begin_strobe_n(bif.cycle_begin_strobe_n),
        .dma_snoop_n(bif.dma_snoop_n), .sample(bif.sample), .early_addr_req_n(bif.early_addr_req_n),
        .dev_ready_oe(bif.dev_ready_oe), .sys_ready_oe(bif.sys_ready_oe), .ready_n(bif.ready_n),
        .main_mem_read_req_n(bif.main_mem_read_req_n), .main_mem_write_req_n(bif.main_mem_write_req_n),
        .main_mem_done_n(bif.main_mem_done_n), .cache_we_n(bif.cache_we_n), .cache_oe_n(bif.cache_oe_n),
        .cache_fault(bif.cache_fault));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Main memory: one ack pulse 1 to 4 cycles after each start
    // ************************************************************
    always @(negedge ref_clk) begin
        mem_ack = (ack_cnt == 1);
        if (ack_cnt > 0) ack_cnt--;
        if (mem_start === 1'b1) begin
            ack_dly = 1 + $urandom % 4;
            ack_cnt = ack_dly;
        end
    end

    // ************************************************************
    // Checks and verdict
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_cyc(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            n_errors++;
            $display("MISMATCH t=%0t miss latency got %0d exp %0d", $time, got, exp);
        end
    endtask : chk_cyc

    task automatic close_out();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // ************************************************************
    // Processor cycles
    // ************************************************************
    task automatic op(input logic [31:2] a, input logic w, m, d, l, input logic [3:0] ln);
        int   k;
        logic nc, port, cach, was, hit;
        nc   = m && d && (a[31:13] == NC_TAG);
        port = !m && (a[7:4] == IO_B);
        cach = m && l && !nc;
        was  = vld.exists(a);
        hit  = (cach && !w && was) || port;
        bif.addr = a;
        bif.write_not_read = w;
        bif.mem_not_io = m;
        bif.data_not_ctrl = d;
        bif.lock_n = l;
        bif.byte_lane_en_n = ln;
        bif.cycle_begin_strobe_n = 1'b0;
        @(negedge ref_clk);
        bif.cycle_begin_strobe_n = 1'b1;
        chk(bif.early_addr_req_n, 0, "next address");
        chk(bif.ready_n, !hit, "hit ready");
        if (!l) chk(excl_hold, 1, "exclusive hold");
        if (hit) begin
            chk(bif.cache_oe_n, port, "ram output enable");
            chk(io_port_hit, port, "port decode");
            if (!port) chk(bif.cache_addr[10:0], a[12:2], "ram address");
        end else begin
            chk(bif.main_mem_read_req_n, w, "read request");
            chk(bif.main_mem_write_req_n, !w, "write request");
            chk(bif.uncached_access_n, !nc, "uncached flag");
            k = 0;
            while (bif.ready_n !== 1'b0 && k < 40) begin
                @(negedge ref_clk);
                k++;
            end
            chk_cyc(k, 2 + ack_dly);
            chk(bif.main_mem_done_n, 0, "done");
            chk(bif.sample, 1, "sample");
            chk(bif.cache_we_n, (cach && !w) ? 4'h0 : ((cach && was) ? ln : 4'hf), "ram write");
            chk(mem_addr, a, "memory address");
            chk(mem_write, w, "memory direction");
            chk(mem_lanes_n, ln, "lanes");
            chk(mem_uncached, nc, "bypass");
            if (cach && !w) vld[a] = 1'b1;
        end
        if (!l) vld.delete(a);
        bif.lock_n = 1'b1;
        @(negedge ref_clk);
    endtask : op

    task automatic snoop(input logic [31:2] a);
        int k;
        dma_req = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(bif.dma_snoop_n, 0, "snoop level");
        bif.addr = a;
        bif.mem_not_io = 1'b1;
        bif.cycle_begin_strobe_n = 1'b0;
        @(negedge ref_clk);
        bif.cycle_begin_strobe_n = 1'b1;
        dma_req = 1'b0;
        for (k = 0; k < 3; k++) begin
            chk(bif.ready_n & bif.main_mem_read_req_n & bif.main_mem_write_req_n, 1, "snoop quiet");
            @(negedge ref_clk);
        end
        vld.delete(a);
    endtask : snoop

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'ha5c8a22d));
        {n_errors, tests_run, ack_cnt, ack_dly} = '0;
        {mem_ack, dma_req, reset_n} = 3'h0;
        io_base = IO_B;
        nc_enable = 1'b1;
        nc_base = {NC_TAG, 11'h000};
        nc_mask = {19'h7ffff, 11'h000};
        bif.addr = '0;
        bif.byte_lane_en_n = 4'hf;
        bif.cycle_begin_strobe_n = 1'b1;
        {bif.write_not_read, bif.mem_not_io, bif.data_not_ctrl, bif.lock_n} = 4'h7;
        repeat (8) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (2000) @(negedge ref_clk);
        chk(bif.sample, 0, "tag sweep");
        n = 0;
        while (bif.sample !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n, cc_pkg::SETS - 2000, "sweep length");
        // Four tags in three sets fill every way but never force an eviction.
        for (i = 0; i < 400; i++) begin
            pa = {19'($urandom % 4 + 1), 11'($urandom % 3) * 11'h155};
            case ($urandom % 8)
                0, 1, 2: op(pa, 1'b0, 1'b1, 1'($urandom), 1'b1, 4'h0);
                3: op(pa, 1'b1, 1'b1, 1'b1, 1'b1, 4'($urandom));
                4: snoop(pa);
                5: op(pa, 1'($urandom), 1'b1, 1'b1, 1'b0, 4'h0);
                6: op({NC_TAG, pa[12:2]}, 1'($urandom), 1'b1, 1'b1, 1'b1, 4'h0);
                default: op({pa[31:8], ($urandom % 2) ? IO_B : 4'h2, pa[3:2]}, 1'($urandom), 1'b0, 1'b1, 1'b1, 4'h0);
            endcase
        end
        chk(bif.cache_fault, 0, "fault");
        close_out();
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        n_errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out();
    end
endmodule : cpu_cache_controller_tb
